// file: hw/adcc_params.svh
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses within the block)
// ----------------------------------------------------------------
`define ADCC_OFS_RES_A_HI   4'h0
`define ADCC_OFS_CTRL       4'h8
`define ADCC_OFS_TRIG       4'h9

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ADCC_BIT_END        7
`define ADCC_BIT_IE         6
`define ADCC_BIT_START      5
`define ADCC_BIT_SCAN       4
`define ADCC_BIT_SPEED      3
`define ADCC_BIT_HWEN       7

// ----------------------------------------------------------------
// Reset values and fixed bits
// ----------------------------------------------------------------
`define ADCC_CTRL_RESET     8'h00
`define ADCC_TRIG_RESET     8'h7F
`define ADCC_TRIG_ONES      8'h7E

// ----------------------------------------------------------------
// Conversion lengths in states
// ----------------------------------------------------------------
`define ADCC_CONV_SLOW      134
`define ADCC_CONV_FAST      70
`define ADCC_SCAN_SLOW      128
`define ADCC_SCAN_FAST      66

`endif

// file: hw/adcc_pkg.sv
package adcc_pkg;

  typedef enum logic [1:0] {
    ADCC_IDLE,
    ADCC_CONV
  } adcc_state_e;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } adcc_bus_s;

  typedef struct packed {
    logic       done;
    logic [9:0] value;
  } adcc_sample_s;

endpackage

// file: hw/adcc_control.sv
`include "adcc_params.svh"
// Contract
// - End flag sets after single conversion, or after the whole scan group.
// - End flag clears only by writing 0 after reading it as 1.
// - Interrupt enable gates the end request; resets to 0.
// - Single mode: start bit holds during conversion, self-clears at end.
// - Scan mode: cycles channels until start cleared, reset or standby.
// - Start bit also set by external trigger or timer compare match.
// - Mode bit: 0 single (reset), 1 scan.
// - Speed bit: 134 states max when 0, 70 states max when 1.
// - Channel bits pick input, or group and count in scan mode.
// - Control/status register resets to 00 on reset and standby.
// - Trigger register resets to 7F on reset and standby.
// - Hardware start sources act only when trigger enable is 1.
// - Pin versus timer source is chosen in the timer block.
// - Trigger register bits 6..1 read 1 and ignore writes.
// - Upper byte read returns it and copies lower byte to holding latch.
// - Lower byte read returns the holding latch.
// - Results left-justified; bits 5..0 of lower byte read zero.
// - Later scan conversions take 128 or 66 states.
// - Falling edge on enabled external pin sets start bit.
// - End flag rising with enable set requests the interrupt.
module adcc_control #(
  parameter int CONV_SLOW = `ADCC_CONV_SLOW,
  parameter int CONV_FAST = `ADCC_CONV_FAST,
  parameter int SCAN_SLOW = `ADCC_SCAN_SLOW,
  parameter int SCAN_FAST = `ADCC_SCAN_FAST
) (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic              standby,
  input  wire adcc_pkg::adcc_bus_s bus,
  output logic [7:0]             rdata,
  input  wire logic              external_start_pin,
  input  wire logic              pin_start_select,
  input  wire logic              timer_compare_match,
  output logic                   conv_start,
  output logic [2:0]             conv_channel,
  input  wire adcc_pkg::adcc_sample_s sample,
  output logic                   conversion_end_irq
);
  import adcc_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic              conversion_end_flag;
  logic              end_interrupt_enable;
  logic              conversion_start_bit;
  logic              scan_mode;
  logic              conversion_speed_select;
  logic [2:0]        input_channel_select;
  logic              hardware_start_enable;
  logic              trig_bit0;
  logic              end_flag_seen;
  logic [9:0]        result_registers [4];
  logic [7:0]        hold_latch;
  logic              pin_prev;
  adcc_state_e       state;
  logic [7:0]        count;
  logic [1:0]        scan_index;
  logic              first_conv;

  function automatic logic [7:0] conv_len(input logic fast,
                                          input logic later);
    int n;
    n = later ? (fast ? SCAN_FAST : SCAN_SLOW)
              : (fast ? CONV_FAST : CONV_SLOW);
    return n[7:0];
  endfunction

  // ----------------------------------------------------------------
  // Start sources
  // ----------------------------------------------------------------
  logic ctrl_wr;
  logic trig_wr;
  logic ctrl_rd;
  logic pin_fall;
  logic hw_start;
  logic conv_done;
  logic last_in_group;
  logic start_clear;

  assign ctrl_wr  = bus.wr && bus.addr == `ADCC_OFS_CTRL;
  assign trig_wr  = bus.wr && bus.addr == `ADCC_OFS_TRIG;
  assign ctrl_rd  = bus.rd && bus.addr == `ADCC_OFS_CTRL;
  // Pin or timer picked by pin_start_select from outside; this block muxes and gates
  assign pin_fall = pin_prev && !external_start_pin;
  assign hw_start = hardware_start_enable &&
                    (pin_start_select ? pin_fall
                                      : timer_compare_match);
  assign conv_done = state == ADCC_CONV && count == 8'h01;
  assign last_in_group = !scan_mode ||
                         scan_index == input_channel_select[1:0];
  assign start_clear = ctrl_wr && !bus.wdata[`ADCC_BIT_START];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_prev <= 1'b1;
    end else begin
      pin_prev <= external_start_pin;
    end
  end

  // ----------------------------------------------------------------
  // Control/status register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      end_interrupt_enable    <= 1'b0;
      scan_mode               <= 1'b0;
      conversion_speed_select <= 1'b0;
      input_channel_select    <= 3'h0;
    end else if (standby) begin
      end_interrupt_enable    <= 1'b0;
      scan_mode               <= 1'b0;
      conversion_speed_select <= 1'b0;
      input_channel_select    <= 3'h0;
    end else if (ctrl_wr) begin
      end_interrupt_enable    <= bus.wdata[`ADCC_BIT_IE];
      scan_mode               <= bus.wdata[`ADCC_BIT_SCAN];
      conversion_speed_select <= bus.wdata[`ADCC_BIT_SPEED];
      input_channel_select    <= bus.wdata[2:0];
    end
  end

  // Software set and hardware set both win over the end-of-run clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      conversion_start_bit <= 1'b0;
    end else if (standby) begin
      conversion_start_bit <= 1'b0;
    end else if (hw_start) begin
      conversion_start_bit <= 1'b1;
    end else if (ctrl_wr) begin
      conversion_start_bit <= bus.wdata[`ADCC_BIT_START];
    end else if (conv_done && !scan_mode) begin
      conversion_start_bit <= 1'b0;
    end
  end

  // Set beats clear; clear needs a prior read of 1
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      conversion_end_flag <= 1'b0;
      end_flag_seen       <= 1'b0;
    end else if (standby) begin
      conversion_end_flag <= 1'b0;
      end_flag_seen       <= 1'b0;
    end else begin
      if (conv_done && last_in_group) begin
        conversion_end_flag <= 1'b1;
      end else if (ctrl_wr && !bus.wdata[`ADCC_BIT_END] &&
                   end_flag_seen) begin
        conversion_end_flag <= 1'b0;
      end
      if (ctrl_rd && conversion_end_flag) begin
        end_flag_seen <= 1'b1;
      end else if (ctrl_wr) begin
        end_flag_seen <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Trigger register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      // Top bit of the trigger reset value is zero
      hardware_start_enable <= 1'b0;
      trig_bit0             <= 1'b1;
    end else if (standby) begin
      hardware_start_enable <= 1'b0;
      trig_bit0             <= 1'b1;
    end else if (trig_wr) begin
      hardware_start_enable <= bus.wdata[`ADCC_BIT_HWEN];
      trig_bit0             <= bus.wdata[0];
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state      <= ADCC_IDLE;
      count      <= 8'h00;
      scan_index <= 2'h0;
      first_conv <= 1'b1;
    end else if (standby || (start_clear && !hw_start)) begin
      state      <= ADCC_IDLE;
      count      <= 8'h00;
      scan_index <= 2'h0;
      first_conv <= 1'b1;
    end else begin
      case (state)
        ADCC_IDLE: begin
          if (conversion_start_bit) begin
            state      <= ADCC_CONV;
            count      <= conv_len(conversion_speed_select, 1'b0);
            scan_index <= 2'h0;
            first_conv <= 1'b1;
          end
        end
        ADCC_CONV: begin
          if (count > 8'h01) begin
            count <= count - 8'h01;
          end else if (scan_mode) begin
            scan_index <= last_in_group ? 2'h0
                                        : scan_index + 2'h1;
            first_conv <= 1'b0;
            count <= conv_len(conversion_speed_select, 1'b1);
          end else begin
            state <= ADCC_IDLE;
          end
        end
        default: state <= ADCC_IDLE;
      endcase
    end
  end

  assign conv_start = state == ADCC_CONV &&
                      count == conv_len(conversion_speed_select, !first_conv);
  assign conv_channel = scan_mode ? {input_channel_select[2], scan_index}
                                  : input_channel_select;

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 4; i++) result_registers[i] <= 10'h000;
    end else if (standby) begin
      for (int i = 0; i < 4; i++) result_registers[i] <= 10'h000;
    end else if (conv_done) begin
      result_registers[conv_channel[1:0]] <= sample.value;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hold_latch <= 8'h00;
    end else if (bus.rd && bus.addr[3] == 1'b0 && !bus.addr[0]) begin
      hold_latch <= {result_registers[bus.addr[2:1]][1:0], 6'h00};
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      if (bus.addr[3] == 1'b0) begin
        rdata <= bus.addr[0] ? hold_latch
                             : result_registers[bus.addr[2:1]][9:2];
      end else if (bus.addr == `ADCC_OFS_CTRL) begin
        rdata <= {conversion_end_flag, end_interrupt_enable,
                  conversion_start_bit, scan_mode,
                  conversion_speed_select, input_channel_select};
      end else if (bus.addr == `ADCC_OFS_TRIG) begin
        rdata <= {hardware_start_enable, 7'h00} | `ADCC_TRIG_ONES |
                 {7'h00, trig_bit0};
      end else begin
        rdata <= 8'h00;
      end
    end
  end

  assign conversion_end_irq = conversion_end_flag &&
                              end_interrupt_enable;

endmodule

// file: testbench/adcc_control_properties.sv
// ------------------------------------------------------------
// Port checks of the converter control block
// ------------------------------------------------------------
module adcc_control_properties #(
  parameter int SCAN_FAST = 66
) (
  input wire logic                clock,
  input wire logic                rstn,
  input wire logic                standby,
  input wire adcc_pkg::adcc_bus_s bus,
  input wire logic [7:0]          rdata,
  input wire logic                conv_start,
  input wire logic                conversion_end_irq
);
  import adcc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Any write or standby may abort a run, so the gap is then not trusted
  logic [7:0] gap;
  logic       gap_ok;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gap    <= 8'h00;
      gap_ok <= 1'b0;
    end else if (standby || bus.wr) begin
      gap_ok <= 1'b0;
    end else if (conv_start) begin
      gap    <= 8'h00;
      gap_ok <= 1'b1;
    end else if (gap != 8'hFF) begin
      gap <= gap + 8'h01;
    end
  end
  sequence s_stby_rd(logic [3:0] a);
    standby ##1 (!standby && bus.rd && bus.addr == a);
  endsequence
  sequence s_quiet;
    standby ##1 (!standby && !bus.wr)[*4];
  endsequence
  AST_CTRL_STBY: assert property (s_stby_rd(4'h8) |=> rdata == 8'h00)
    else $error("control register not cleared by standby");
  AST_TRIG_STBY: assert property (s_stby_rd(4'h9) |=> rdata == 8'h7F)
    else $error("trigger register not restored by standby");
  AST_TRIG_ONES: assert property (bus.rd && bus.addr == 4'h9 |=> rdata[6:1] == 6'h3F)
    else $error("trigger register fixed bits not one");
  AST_LO_ZERO: assert property (bus.rd && bus.addr < 4'h8 && bus.addr[0] |=> rdata[5:0] == 6'h00)
    else $error("result low byte spare bits not zero");
  AST_SCAN_GAP: assert property (conv_start && gap_ok |-> gap >= SCAN_FAST - 1)
    else $error("conversion shorter than allowed");
  AST_HW_OFF: assert property (s_quiet |-> !conv_start)
    else $error("conversion began without any start source");
  AST_IRQ_STBY: assert property (standby |=> !conversion_end_irq)
    else $error("end request left up by standby");
  AST_IRQ_HOLD: assert property (conversion_end_irq && !bus.wr && !standby |=> conversion_end_irq)
    else $error("end request dropped without a write");
endmodule
bind adcc_control adcc_control_properties #(.SCAN_FAST(SCAN_FAST)) i_props (
  .clock(clock), .rstn(rstn), .standby(standby), .bus(bus), .rdata(rdata),
  .conv_start(conv_start), .conversion_end_irq(conversion_end_irq)
);

// file: testbench/adcc_cpu_model.sv
// ------------------------------------------------------------
// CPU side of the byte-wide register bus
// ------------------------------------------------------------
module adcc_cpu_model (
  input  wire logic           clock,
  output adcc_pkg::adcc_bus_s bus,
  input  wire logic [7:0]     rdata
);
  import adcc_pkg::*;
  initial bus = '0;
  // Held over the taking edge; idle bus shows junk, not the last value
  task automatic access(input logic w, input logic [3:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(negedge clock);
    bus <= '{rd: !w, wr: w, addr: a, wdata: (a == 4'h9) ? d & 8'hFE : d};
    @(negedge clock);
    q = rdata;
    bus <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule

// file: testbench/tb_adcc_control.sv
`include "adcc_params.svh"
// ------------------------------------------------------------
// Self-checking bench of the converter control block
// ------------------------------------------------------------
module tb_adcc_control;
  timeunit 1ns;
  timeprecision 1ps;
  import adcc_pkg::*;
  logic         clock, rstn, standby, ext_pin, pin_sel, tmatch, conv_start;
  logic         irq;
  logic [7:0]   rdata, q;
  logic [2:0]   chan;
  logic [9:0]   vbase, v;
  adcc_bus_s    bus;
  adcc_sample_s sample;
  integer       seed, num_errors, comparisons;
  adcc_cpu_model i_cpu (.clock(clock), .bus(bus), .rdata(rdata));
  adcc_control i_dut (
    .clock(clock), .rstn(rstn), .standby(standby), .bus(bus), .rdata(rdata),
    .external_start_pin(ext_pin), .pin_start_select(pin_sel),
    .timer_compare_match(tmatch), .conv_start(conv_start),
    .conv_channel(chan), .sample(sample), .conversion_end_irq(irq)
  );
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  function automatic logic [9:0] exp_val(input logic [2:0] c);
    return vbase ^ {c, c, c, 1'b1};
  endfunction
  always @(negedge clock) sample <= '{done: 1'b0, value: exp_val(chan)};
  task automatic cmp_byte(input logic [7:0] act, input logic [7:0] exp);
    comparisons++;
    if (act !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, act, exp);
    end
  endtask
  task automatic cmp_bit(input logic act, input logic exp);
    cmp_byte({7'h00, act}, {7'h00, exp});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_cpu.access(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    i_cpu.access(1'b0, a, 8'h00, q);
    cmp_byte(q, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic stby_rd(input logic [3:0] a, input logic [7:0] exp);
    cyc(1);
    standby = 1'b1;
    fork
      begin
        cyc(1);
        standby = 1'b0;
      end
    join_none
    rdc(a, exp);
  endtask
  task automatic single(input logic [2:0] ch, input logic spd, input logic ie);
    logic [7:0] c;
    c = {1'b0, ie, 1'b1, 1'b0, spd, ch};
    vbase = $random(seed);
    v = exp_val(ch);
    wr(4'h8, c);
    cyc((spd ? `ADCC_CONV_FAST : `ADCC_CONV_SLOW) - 4);
    cmp_bit(irq, 1'b0);
    cyc(8);
    cmp_bit(irq, ie);
    wr(4'h8, c & 8'h5F);
    rdc(4'h8, c ^ 8'hA0);
    wr(4'h8, c & 8'h5F);
    rdc(4'h8, c & 8'h5F);
    cmp_bit(irq, 1'b0);
    rdc({1'b0, ch[1:0], 1'b0}, v[9:2]);
    rdc({1'b0, ch[1:0], 1'b1}, {v[1:0], 6'h00});
    $display("single channel %0d done", ch);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    seed = 37486;
    num_errors = 0;
    comparisons = 0;
    {rstn, standby, tmatch, vbase} = '0;
    {ext_pin, pin_sel} = 2'b11;
    cyc(10);
    rstn = 1'b1;
    rdc(4'h8, `ADCC_CTRL_RESET);
    rdc(4'h9, `ADCC_TRIG_RESET);
    wr(4'h9, 8'h00);
    rdc(4'h9, 8'h7E);
    for (int i = 0; i < 8; i++) single(3'(i), 1'($random(seed)), i[0]);
    vbase = $random(seed);
    wr(4'h8, 8'h7E);
    cyc(`ADCC_CONV_FAST + 2 * `ADCC_SCAN_FAST - 4);
    cmp_bit(irq, 1'b0);
    cyc(8);
    cmp_bit(irq, 1'b1);
    for (int i = 0; i < 3; i++) begin
      v = exp_val(3'(4 + i));
      rdc(4'(2 * i), v[9:2]);
      rdc(4'(2 * i + 1), {v[1:0], 6'h00});
    end
    v = exp_val(3'h4);
    rdc(4'h0, v[9:2]);
    rdc(4'h7, {v[1:0], 6'h00});
    rdc(4'h8, 8'hFE);
    wr(4'h8, 8'h5E);
    cyc(2 * `ADCC_CONV_FAST + 2 * `ADCC_SCAN_FAST);
    rdc(4'h8, 8'h5E);
    $display("scan test done");
    wr(4'h8, 8'h40);
    ext_pin = 1'b0;
    cyc(3);
    {ext_pin, pin_sel, tmatch} = 3'b101;
    cyc(1);
    tmatch = 1'b0;
    rdc(4'h8, 8'h40);
    wr(4'h9, 8'h81);
    rdc(4'h9, 8'hFE);
    tmatch = 1'b1;
    cyc(1);
    tmatch = 1'b0;
    rdc(4'h8, 8'h60);
    cyc(`ADCC_CONV_SLOW + 4);
    rdc(4'h8, 8'hC0);
    wr(4'h8, 8'h40);
    {ext_pin, pin_sel} = 2'b01;
    cyc(3);
    ext_pin = 1'b1;
    rdc(4'h8, 8'h60);
    $display("trigger test done");
    stby_rd(4'h8, 8'h00);
    stby_rd(4'h9, 8'h7F);
    cmp_bit(irq, 1'b0);
    $display("standby test done");
    print_verdict();
  end
  // Run needs under 2000 cycles; fifteen times that means a hang
  initial begin
    repeat (30000) @(posedge clock);
    num_errors++;
    print_verdict();
  end
endmodule
